// File: include/thermal_pkg.sv
/*
 * Shared constants of the thermal clock throttle.
 * Assumes a 10 MHz core clock.
 */
package thermal_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL      = 4'h0;  // on-demand control
    localparam logic [3:0] ADDR_MODE      = 4'h1;  // auto enable, forced, irq enables
    localparam logic [3:0] ADDR_STATUS    = 4'h2;  // live and sticky status
    localparam logic [3:0] ADDR_TEMP0     = 4'h3;  // core 0 relative temperature
    localparam logic [3:0] ADDR_TEMP1     = 4'h4;  // core 1 relative temperature
    localparam logic [3:0] ADDR_THRESH    = 4'h5;  // thresholds A and B

    // control register fields
    localparam int CTRL_ONDEMAND_BIT  = 4;
    localparam int CTRL_DUTY_LSB      = 1;
    localparam int CTRL_DUTY_MSB      = 3;

    // mode register fields
    localparam int MODE_AUTO_BIT      = 0;
    localparam int MODE_FORCE_BIT     = 1;
    localparam int MODE_IRQ_ASSERT    = 2;
    localparam int MODE_IRQ_DEASSERT  = 3;
    localparam int MODE_IRQ_OOS       = 4;
    localparam int MODE_IRQ_THA       = 5;
    localparam int MODE_IRQ_THB       = 6;

    // status fields, sticky bits write-one-to-clear
    localparam int ST_HOT_LIVE        = 0;
    localparam int ST_HOT_ROSE        = 1;
    localparam int ST_HOT_FELL        = 2;
    localparam int ST_OOS_LIVE        = 3;
    localparam int ST_OOS_STICKY      = 4;
    localparam int ST_THA_CROSS       = 5;
    localparam int ST_THB_CROSS       = 6;
    localparam int ST_TCC_ACTIVE      = 7;
    localparam int ST_WIDTH           = 8;

    localparam logic [7:0] MODE_RESET = 8'h01;  // auto mode on by default

    // power states
    typedef enum logic [2:0] {
        PS_NORMAL,
        PS_STOP_GRANT,
        PS_SLEEP,
        PS_DEEP_SLEEP,
        PS_DEEP_POWER_DOWN
    } pstate_e;

    // timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int MOD_PERIOD_US   = 8;
    localparam int MOD_PERIOD_CYC  = MOD_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int OOS_DWELL_US    = 1000;
    localparam int OOS_DWELL_CYC   = OOS_DWELL_US * (CLK_HZ / 1_000_000);
    localparam int HYST_STEPS      = 2;    // readout steps below trip to release
endpackage

// File: hdl/thermal_clock_throttle.sv
/*
 * Thermal clock throttle: trip with hysteresis, clock modulation, hot pin,
 * catastrophic trip, readout, out-of-spec and threshold events.
 * Assumes asynchronous sensor inputs and a register master on this clock.
 */
// The plain strobed port and the address map were decided locally.
// Overview of operation
// [RQ1] fixed trip at maximum temperature activates control
// [RQ2] snoop and interrupts continue while throttling
// [RQ3] throttle only by gating core clocks
// [RQ4] automatic mode beats on-demand mode
// [RQ5] automatic throttles only at trip temperature; code also throttles whenever the force bit is set while auto enable is on
// [RQ6] automatic duty fixed at fifty percent
// [RQ7] release with hysteresis below trip
// [RQ8] control bit 4 forces on-demand throttling
// [RQ9] bits 3:1 set on-demand duty in eighths
// [RQ10] one hot pin, either core, both modulated
// [RQ11] interrupt on hot assert and/or deassert
// [RQ12] no new hot assert in low-power states
// [RQ13] hot pin released in deepest power-down
// [RQ14] catastrophic trip output, no bus cycles
// [RQ15] platform removes core supply after trip
// [RQ16] per-core readout valid only in normal state
// [RQ17] readout relative, never above maximum
// [RQ18] out-of-spec live and sticky bit, interrupt
// [RQ19] automatic trigger equals readout at maximum
// [RQ20] two programmable thresholds raise interrupts
// [RQ21] external pin pull-down throttles both cores
// [RQ22] forced setting ignores external hot pin
// [RQ23] pin synchronised, driven low only
`timescale 1ns/10ps
module thermal_clock_throttle #(
    parameter int TW         = 7,
    parameter int OOS_CYCLES = thermal_pkg::OOS_DWELL_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // sensors: distance below maximum per core, and catastrophic comparator
    input  wire logic [TW-1:0]     core0Margin,
    input  wire logic [TW-1:0]     core1Margin,
    input  wire logic              catastrophicHot,
    input  wire logic [2:0]        powerState,
    // open-drain hot indicator pin
    input  wire logic              hotIndicatorNIn,
    output logic                   hotIndicatorNOut,
    output logic                   hotIndicatorNOe,
    // catastrophic trip pin and clock gates
    output logic                   catastrophicTripN,
    output logic [1:0]             coreClockEnable,
    output logic                   thermalIrq,
    // register port
    input  wire logic [3:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic [31:0]            regRdata
);
    // ----------------------------------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0]    rstSync_ff;
    logic          rstnInt;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) rstSync_ff <= 2'h0;
        else       rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
    assign rstnInt = rstSync_ff[1];

    logic [TW-1:0] m0Meta_ff, m0_ff, m1Meta_ff, m1_ff;
    logic [1:0]    extMeta_ff, ext_ff;   // {catastrophic, pin}
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            m0Meta_ff  <= '1;
            m0_ff      <= '1;
            m1Meta_ff  <= '1;
            m1_ff      <= '1;
            extMeta_ff <= 2'h1;
            ext_ff     <= 2'h1;
        end
        else
        begin
            m0Meta_ff  <= core0Margin;
            m0_ff      <= m0Meta_ff;
            m1Meta_ff  <= core1Margin;
            m1_ff      <= m1Meta_ff;
            extMeta_ff <= {catastrophicHot, hotIndicatorNIn};  // [RQ23]
            ext_ff     <= extMeta_ff;
        end
    end

    logic pinLow, catHot;
    assign pinLow = ~ext_ff[0];
    assign catHot = ext_ff[1];

    thermal_pkg::pstate_e pstate;
    assign pstate = thermal_pkg::pstate_e'(powerState);
    logic lowPower, deepDown;
    assign deepDown = (pstate == thermal_pkg::PS_DEEP_POWER_DOWN);
    assign lowPower = (pstate != thermal_pkg::PS_NORMAL);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [4:0]          ctrl_ff;
    logic [7:0]          mode_ff;
    logic [TW-1:0]       thA_ff, thB_ff;
    logic [thermal_pkg::ST_WIDTH-1:0] sticky_ff;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] want, input logic s);
        hit = s && (a == want);
    endfunction

    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            ctrl_ff <= 5'h00;
            mode_ff <= thermal_pkg::MODE_RESET;
            thA_ff  <= '0;
            thB_ff  <= '0;
        end
        else
        begin
            if (hit(regAddr, thermal_pkg::ADDR_CTRL, regWrite))
                ctrl_ff <= regWdata[4:0];    // [RQ8] [RQ9]
            if (hit(regAddr, thermal_pkg::ADDR_MODE, regWrite))
                mode_ff <= regWdata[7:0];
            if (hit(regAddr, thermal_pkg::ADDR_THRESH, regWrite))
            begin
                thA_ff <= regWdata[TW-1:0];
                thB_ff <= regWdata[16+TW-1:16];
            end
        end
    end

    logic autoEn, forceEn, onDemand;
    logic [2:0] duty;
    assign autoEn   = mode_ff[thermal_pkg::MODE_AUTO_BIT];
    assign forceEn  = mode_ff[thermal_pkg::MODE_FORCE_BIT];
    assign onDemand = ctrl_ff[thermal_pkg::CTRL_ONDEMAND_BIT];
    assign duty     = ctrl_ff[thermal_pkg::CTRL_DUTY_MSB:thermal_pkg::CTRL_DUTY_LSB];

    // ----------------------------------------------------------------
    // trip detection with hysteresis
    // ----------------------------------------------------------------
    // margin zero means the core sits at maximum; the trip point is not writable
    logic [1:0] tripped_ff;
    logic [TW-1:0] margin [2];
    assign margin = '{m0_ff, m1_ff};
    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_trip
            always_ff @(posedge clock or negedge rstnInt)
            begin
                if (!rstnInt)
                    tripped_ff[c] <= 1'b0;
                else if (margin[c] == '0)
                    tripped_ff[c] <= 1'b1;                   // [RQ1] [RQ19]
                else if (margin[c] >= TW'(thermal_pkg::HYST_STEPS))
                    tripped_ff[c] <= 1'b0;                   // [RQ7]
            end
        end
    endgenerate

    logic anyTrip;
    assign anyTrip = |tripped_ff;   // [RQ10]

    // ----------------------------------------------------------------
    // hot indicator pin
    // ----------------------------------------------------------------
    logic hotDrive_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
            hotDrive_ff <= 1'b0;
        else if (deepDown)
            hotDrive_ff <= 1'b0;                             // [RQ13]
        else if (!lowPower)
            hotDrive_ff <= anyTrip;                          // [RQ10] [RQ12] held in low power
    end
    assign hotIndicatorNOut = 1'b0;                          // [RQ23] low only
    assign hotIndicatorNOe  = hotDrive_ff;

    // pin low from outside, not from our own drive
    logic extRequest;
    assign extRequest = pinLow && !hotDrive_ff;              // [RQ21]

    // ----------------------------------------------------------------
    // modulation
    // ----------------------------------------------------------------
    localparam int STEP = thermal_pkg::MOD_PERIOD_CYC / 8;
    logic [$clog2(STEP)-1:0] div_ff;
    logic [2:0]              phase_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            div_ff   <= '0;
            phase_ff <= 3'h0;
        end
        else if (div_ff == ($clog2(STEP))'(STEP - 1))
        begin
            div_ff   <= '0;
            phase_ff <= phase_ff + 3'h1;
        end
        else
            div_ff <= div_ff + 1'b1;
    end

    // force throttles whenever auto is on, with or without a trip or pin request
    logic autoThrottle, tccActive, clkOn;
    assign autoThrottle = autoEn && ((anyTrip || forceEn) || extRequest); // [RQ5] [RQ22]
    assign tccActive    = autoThrottle || onDemand;
    always_comb
    begin
        if (autoThrottle)
            clkOn = (phase_ff < 3'h4);                       // [RQ4] [RQ6]
        else if (onDemand)
            clkOn = (phase_ff < duty);                       // [RQ8] [RQ9]
        else
            clkOn = 1'b1;
    end

    // both cores gated together; interrupts and snoops live outside the gate
    logic [1:0] clkEn_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt) clkEn_ff <= 2'h3;
        else          clkEn_ff <= {2{clkOn}};                // [RQ3] [RQ10] [RQ2]
    end
    assign coreClockEnable = clkEn_ff;

    // ----------------------------------------------------------------
    // catastrophic trip: latched until reset, independent of software
    // ----------------------------------------------------------------
    logic catTrip_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)    catTrip_ff <= 1'b0;
        else if (catHot) catTrip_ff <= 1'b1;                 // [RQ14]
    end
    assign catastrophicTripN = ~catTrip_ff;

    // ----------------------------------------------------------------
    // out-of-spec: auto throttling held hot for the dwell
    // ----------------------------------------------------------------
    logic [$clog2(OOS_CYCLES+1)-1:0] dwell_ff;
    logic oosLive;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
            dwell_ff <= '0;
        else if (!(autoEn && anyTrip))
            dwell_ff <= '0;
        else if (!oosLive)
            dwell_ff <= dwell_ff + 1'b1;                     // [RQ18]
    end
    assign oosLive = (dwell_ff == ($clog2(OOS_CYCLES+1))'(OOS_CYCLES));

    // ----------------------------------------------------------------
    // readout, clamped at maximum and frozen outside normal state
    // ----------------------------------------------------------------
    logic [TW-1:0] read0_ff, read1_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            read0_ff     <= '0;
            read1_ff     <= '0;
        end
        else
        begin
            if (!lowPower)                                   // [RQ16] frozen outside normal
            begin
                read0_ff <= m0_ff;                           // [RQ17] unsigned margin
                read1_ff <= m1_ff;
            end
        end
    end

    // threshold crossings on the hotter core, either direction
    logic [TW-1:0] hottest;
    logic          aboveA_ff, aboveB_ff;
    assign hottest = (m0_ff < m1_ff) ? m0_ff : m1_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            aboveA_ff <= 1'b0;
            aboveB_ff <= 1'b0;
        end
        else
        begin
            aboveA_ff <= hottest <= thA_ff;
            aboveB_ff <= hottest <= thB_ff;
        end
    end

    // ----------------------------------------------------------------
    // status: set wins over write-one-to-clear
    // ----------------------------------------------------------------
    logic hotPrev_ff;
    logic [thermal_pkg::ST_WIDTH-1:0] setEv, clrEv;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt) hotPrev_ff <= 1'b0;
        else          hotPrev_ff <= pinLow;
    end
    always_comb
    begin
        setEv = '0;
        setEv[thermal_pkg::ST_HOT_ROSE]   = pinLow && !hotPrev_ff;   // [RQ11]
        setEv[thermal_pkg::ST_HOT_FELL]   = !pinLow && hotPrev_ff;   // [RQ11]
        setEv[thermal_pkg::ST_OOS_STICKY] = oosLive;                 // [RQ18]
        setEv[thermal_pkg::ST_THA_CROSS]  = aboveA_ff != (hottest <= thA_ff); // [RQ20]
        setEv[thermal_pkg::ST_THB_CROSS]  = aboveB_ff != (hottest <= thB_ff); // [RQ20]
        clrEv = hit(regAddr, thermal_pkg::ADDR_STATUS, regWrite)
              ? regWdata[thermal_pkg::ST_WIDTH-1:0] : '0;
    end
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt) sticky_ff <= '0;
        else          sticky_ff <= (sticky_ff & ~clrEv) | setEv;
    end

    logic [thermal_pkg::ST_WIDTH-1:0] status;
    always_comb
    begin
        status = sticky_ff;
        status[thermal_pkg::ST_HOT_LIVE]   = pinLow;
        status[thermal_pkg::ST_OOS_LIVE]   = oosLive;
        status[thermal_pkg::ST_TCC_ACTIVE] = tccActive;
    end

    logic irq_ff;
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
            irq_ff <= 1'b0;
        else
            irq_ff <= (sticky_ff[thermal_pkg::ST_HOT_ROSE]  && mode_ff[thermal_pkg::MODE_IRQ_ASSERT])
                   || (sticky_ff[thermal_pkg::ST_HOT_FELL]  && mode_ff[thermal_pkg::MODE_IRQ_DEASSERT])
                   || (sticky_ff[thermal_pkg::ST_OOS_STICKY] && mode_ff[thermal_pkg::MODE_IRQ_OOS])
                   || (sticky_ff[thermal_pkg::ST_THA_CROSS] && mode_ff[thermal_pkg::MODE_IRQ_THA])
                   || (sticky_ff[thermal_pkg::ST_THB_CROSS] && mode_ff[thermal_pkg::MODE_IRQ_THB]);
    end
    assign thermalIrq = irq_ff;

    // ----------------------------------------------------------------
    // read port: data in the cycle after the strobe, zero otherwise
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
            regRdata <= 32'h0;
        else if (!regRead)
            regRdata <= 32'h0;
        else
        begin
            unique case (regAddr)
                thermal_pkg::ADDR_CTRL:   regRdata <= {27'h0, ctrl_ff};
                thermal_pkg::ADDR_MODE:   regRdata <= {24'h0, mode_ff};
                thermal_pkg::ADDR_STATUS: regRdata <= {24'h0, status};
                thermal_pkg::ADDR_TEMP0:  regRdata <= {!lowPower, (31-TW)'(0), read0_ff}; // [RQ16]
                thermal_pkg::ADDR_TEMP1:  regRdata <= {!lowPower, (31-TW)'(0), read1_ff}; // [RQ16]
                thermal_pkg::ADDR_THRESH: regRdata <= {(16-TW)'(0), thB_ff,
                                                        (16-TW)'(0), thA_ff};
                default:                  regRdata <= 32'h0;
            endcase
        end
    end
endmodule

// File: sim/thermal_props.sv
/*
 * Port checker for the thermal clock throttle.
 * Assumes binding onto its top module.
 */
`timescale 1ns/10ps
module thermal_props #(
    parameter int TW = 7
) (
    // clock and reset
    input wire logic          clock,
    input wire logic          rstn,
    // sensors and pin
    input wire logic [TW-1:0] core0Margin,
    input wire logic [TW-1:0] core1Margin,
    input wire logic          catastrophicHot,
    input wire logic [2:0]    powerState,
    input wire logic          hotIndicatorNOut,
    input wire logic          hotIndicatorNOe,
    // trip and gates
    input wire logic          catastrophicTripN,
    input wire logic [1:0]    coreClockEnable,
    // register port
    input wire logic [3:0]    regAddr,
    input wire logic          regRead,
    input wire logic [31:0]   regRdata
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic lowPower, cool, atMax;
    assign lowPower = powerState inside {3'h1, 3'h2, 3'h3};
    assign atMax = (core0Margin == '0 || core1Margin == '0) && powerState == 3'h0;
    assign cool = core0Margin >= thermal_pkg::HYST_STEPS
        && core1Margin >= thermal_pkg::HYST_STEPS && powerState == 3'h0;

    AST_CLOCKS_PAIRED: assert property (coreClockEnable[0] == coreClockEnable[1])
        else $error("core clock enables differ");
    AST_PIN_LOW_ONLY: assert property (hotIndicatorNOut == 1'b0)
        else $error("hot pin driven high");
    AST_TRIP_HELD: assert property (!catastrophicTripN |=> !catastrophicTripN)
        else $error("catastrophic trip released");
    AST_TRIP_FAST: assert property ($rose(catastrophicHot) |-> ##[1:8] !catastrophicTripN)
        else $error("catastrophic trip late");
    AST_HOT_AT_MAX: assert property (atMax [*8] |-> hotIndicatorNOe)
        else $error("hot pin not driven at maximum");
    AST_HOT_RELEASE: assert property (cool [*8] |-> !hotIndicatorNOe)
        else $error("hot pin held while cool");
    AST_NO_NEW_HOT: assert property (lowPower [*2] ##0 !hotIndicatorNOe |=> !hotIndicatorNOe)
        else $error("hot pin newly driven in low power");
    AST_HOT_STAYS: assert property (lowPower [*2] ##0 hotIndicatorNOe |=> hotIndicatorNOe)
        else $error("hot pin dropped in low power");
    AST_DEEP_RELEASE: assert property ((powerState == 3'h4) [*2] |-> !hotIndicatorNOe)
        else $error("hot pin driven in deep power down");
    AST_RDATA_IDLE: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data without read");
    AST_UNMAPPED: assert property (regRead && regAddr > thermal_pkg::ADDR_THRESH
        |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    AST_TEMP_VALID: assert property (regRead && regAddr == thermal_pkg::ADDR_TEMP0
        && powerState != 3'h0 |=> !regRdata[31])
        else $error("readout valid outside normal state");

    cover property ($fell(hotIndicatorNOe));
    cover property ($fell(coreClockEnable[0]));
    cover property ($fell(catastrophicTripN));
endmodule

bind thermal_clock_throttle thermal_props #(.TW(TW)) props (
    .clock(clock), .rstn(rstn), .core0Margin(core0Margin), .core1Margin(core1Margin),
    .catastrophicHot(catastrophicHot), .powerState(powerState),
    .hotIndicatorNOut(hotIndicatorNOut), .hotIndicatorNOe(hotIndicatorNOe),
    .catastrophicTripN(catastrophicTripN), .coreClockEnable(coreClockEnable),
    .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata)
);

// File: sim/platform_monitor.sv
/*
 * Platform model: pulled-up hot pin, external agent, core supply cut on trip.
 * Assumes the bench raises pullLow as the external agent.
 */
`timescale 1ns/10ps
module platform_monitor #(
    parameter int SHUT_CYC = 4
) (
    // clock
    input wire logic  clock,
    // device side of pin and trip
    input wire logic  hotIndicatorNOut,
    input wire logic  hotIndicatorNOe,
    input wire logic  catastrophicTripN,
    // external agent request
    input wire logic  pullLow,
    // wire level and supply
    output logic      pinLevel,
    output logic      supplyOn
);
    int tripCount = 0;
    // pull-up: a released line reads high, either party may pull it low
    assign pinLevel = !((hotIndicatorNOe && !hotIndicatorNOut) || pullLow);
    always @(posedge clock)
    begin
        if (catastrophicTripN)
            tripCount <= 0;
        else if (tripCount < SHUT_CYC)
            tripCount <= tripCount + 1;
    end
    assign supplyOn = tripCount < SHUT_CYC;
endmodule

// File: sim/thermal_clock_throttle_bench.sv
/*
 * Self-checking bench for the thermal clock throttle.
 * Assumes the platform model on the hot pin.
 */
`timescale 1ns/10ps
module thermal_clock_throttle_bench;
    localparam int PER = thermal_pkg::MOD_PERIOD_CYC;
    localparam int PH = PER / 8;
    localparam logic [3:0] CT = thermal_pkg::ADDR_CTRL, MD = thermal_pkg::ADDR_MODE;
    localparam logic [3:0] ST = thermal_pkg::ADDR_STATUS, TH = thermal_pkg::ADDR_THRESH;
    logic clock = 0, rstn = 0, catastrophicHot = 0, pullLow = 0;
    logic [6:0] core0Margin = 7'h14, core1Margin = 7'h1e;
    logic [2:0] powerState = 3'h0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, d;
    logic regWrite = 0, regRead = 0, pinLevel, supplyOn;
    logic hotIndicatorNOut, hotIndicatorNOe, catastrophicTripN, thermalIrq;
    logic [1:0] coreClockEnable;
    int mismatches = 0, tests_run = 0;

    always #50 clock = ~clock;

    thermal_clock_throttle #(.TW(7), .OOS_CYCLES(20)) dut (
        .clock(clock), .rstn(rstn), .core0Margin(core0Margin), .core1Margin(core1Margin),
        .catastrophicHot(catastrophicHot), .powerState(powerState),
        .hotIndicatorNIn(pinLevel), .hotIndicatorNOut(hotIndicatorNOut),
        .hotIndicatorNOe(hotIndicatorNOe), .catastrophicTripN(catastrophicTripN),
        .coreClockEnable(coreClockEnable), .thermalIrq(thermalIrq), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    platform_monitor #(.SHUT_CYC(4)) platform (.clock(clock),
        .hotIndicatorNOut(hotIndicatorNOut), .hotIndicatorNOe(hotIndicatorNOe),
        .catastrophicTripN(catastrophicTripN), .pullLow(pullLow), .pinLevel(pinLevel),
        .supplyOn(supplyOn));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        regWrite <= 1'b1; regAddr <= a; regWdata <= v;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        regRead <= 1'b1; regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        d = regRdata;
    endtask
    // settle, then count enabled cycles over one period
    task automatic duty_is(input int exp);
        int n;
        n = 0;
        repeat (2 * PER) @(posedge clock);
        repeat (PER)
        begin
            @(posedge clock);
            if (coreClockEnable[0] === 1'b1) n++;
        end
        check(n, exp);
    endtask
    task automatic wait_oe(input logic exp);
        for (int i = 0; i < 20 && hotIndicatorNOe !== exp; i++) @(posedge clock);
        check(hotIndicatorNOe, exp);
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(MD); check(d, 32'h1);
        rd(CT); check(d, 32'h0);
        rd(4'hf); check(d, 32'h0);
        rd(thermal_pkg::ADDR_TEMP0); check(d, 32'h8000_0014);
        rd(thermal_pkg::ADDR_TEMP1); check(d, 32'h8000_001e);
        duty_is(PER);
    endtask
    task automatic t_auto();
        core1Margin <= 7'h0;
        wait_oe(1'b1);
        duty_is(PER / 2);
        wr(CT, 32'h12);
        duty_is(PER / 2);
        wr(CT, 32'h0);
        rd(ST); check(d[7:3], 5'h1f);
        wr(MD, 32'h11);
        repeat (2) @(negedge clock); check(thermalIrq, 1'b1);
        core1Margin <= 7'h1;
        repeat (12) @(posedge clock); check(hotIndicatorNOe, 1'b1);
        core1Margin <= 7'h2;
        wait_oe(1'b0);
        duty_is(PER);
        rd(ST); check(d[4:3], 2'b10);
        wr(ST, 32'h76);
        repeat (2) @(negedge clock); check(thermalIrq, 1'b0);
        wr(MD, 32'h1);
        core1Margin <= 7'h1e;
    endtask
    task automatic t_ondemand();
        for (int dc = 1; dc < 8; dc++)
        begin
            wr(CT, 32'h10 | (dc << 1));
            duty_is(dc * PH);
        end
        wr(CT, 32'h0);
        duty_is(PER);
    endtask
    task automatic t_pin();
        wr(MD, 32'h05);
        pullLow <= 1'b1;
        duty_is(PER / 2);
        rd(ST); check(d[1:0], 2'b11);
        check(thermalIrq, 1'b1);
        wr(MD, 32'h02);
        duty_is(PER);
        pullLow <= 1'b0;
        wr(MD, 32'h09);
        repeat (4) @(posedge clock); check(thermalIrq, 1'b1);
        wr(ST, 32'h06);
        repeat (2) @(negedge clock); check(thermalIrq, 1'b0);
        wr(MD, 32'h1);
    endtask
    task automatic t_lowpower();
        core0Margin <= 7'h0;
        wait_oe(1'b1);
        powerState <= thermal_pkg::PS_SLEEP;
        core0Margin <= 7'h5;
        repeat (12) @(posedge clock); check(hotIndicatorNOe, 1'b1);
        rd(thermal_pkg::ADDR_TEMP0);  check(d[31], 1'b0);
        powerState <= thermal_pkg::PS_DEEP_POWER_DOWN;
        wait_oe(1'b0);
        powerState <= thermal_pkg::PS_STOP_GRANT;
        core0Margin <= 7'h0;
        repeat (12) @(posedge clock); check(hotIndicatorNOe, 1'b0);
        powerState <= thermal_pkg::PS_NORMAL;
        wait_oe(1'b1);
        core0Margin <= 7'h14;
        wait_oe(1'b0);
    endtask
    task automatic t_thresh();
        wr(TH, 32'h0000_000a);
        wr(ST, 32'h60);
        wr(MD, 32'h21);
        core0Margin <= 7'h5;
        repeat (12) @(posedge clock);
        rd(ST); check(d[5], 1'b1);
        check(thermalIrq, 1'b1);
        core0Margin <= 7'h14;
        repeat (12) @(posedge clock);
        wr(ST, 32'h20);
        repeat (2) @(negedge clock); check(thermalIrq, 1'b0);
    endtask
    task automatic t_trip();
        catastrophicHot <= 1'b1;
        for (int i = 0; i < 10 && catastrophicTripN !== 1'b0; i++) @(posedge clock);
        check(catastrophicTripN, 1'b0);
        catastrophicHot <= 1'b0;
        repeat (10) @(posedge clock); check(catastrophicTripN, 1'b0);
        check(supplyOn, 1'b0);
        do_reset();
        check(catastrophicTripN, 1'b1);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        do_reset();
        t_regs();
        t_auto();
        t_ondemand();
        t_pin();
        t_lowpower();
        t_thresh();
        t_trip();
        final_report();
    end
    // run is about 3.6k cycles; allow over five times that
    initial
    begin
        #2_000_000;
        mismatches++;
        final_report();
    end
endmodule
